// file: src/watchdog_timer_regs.sv
// watchdog timer with apb register slave
// Notes on behaviour
// (R1) writing reload_interval loads the 32-bit counter at once and restarts countdown
// (R2) writing zero to reload_interval raises the time-out interrupt immediately
// (R3) current_count reads the live counter; writes do nothing
// (R4) control bit 0 starts counter and interrupt; then control is frozen until reset
// (R5) control bit 1 lets a second time-out drive the system reset output
// (R6) any write to interrupt_clear reloads the counter and clears the interrupt, unless a time-out in the same cycle sets it again
// (R7) interrupt_clear read value is undefined; do not check it
// (R8) raw_irq_status bit 0 shows the unmasked time-out interrupt
// (R9) masked_irq_status bit 0 is raw AND enable, and drives timeout_irq
// (R10) with stall bit 8 set, counter freezes while cpu is halted
// (R11) writing the key to write_lock opens writes to all other registers
// (R12) writing any other value to write_lock closes writes to other registers
// (R13) write_lock reads one when locked, zero when unlocked
// (R14) ident registers are constant bytes in bits 7:0, upper bits zero
// (R15) software keeps reserved bits on read-modify-write and ignores their value
// (R16) first time-out raises interrupt and reloads; second uncleared one resets if enabled
// (R17) enabling the interrupt preloads the counter from reload_interval
// (R18) running counter drops by one each cycle; zero is a time-out
`timescale 1ns/1ps
`default_nettype none

module watchdog_timer_regs #(
  parameter logic [7:0] ident_field_4 = 8'h00, // arbitrary value
  parameter logic [7:0] ident_field_5 = 8'h00, // arbitrary value
  parameter logic [7:0] ident_field_6 = 8'h00 // arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_halted,
  output logic timeout_irq,
  output logic sys_reset_out,
  output logic evt_irq
);

  watchdog_timer_regs_pkg::wdt_state_type s_q;
  watchdog_timer_regs_pkg::wdt_state_type s_d;

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr == off);
  endfunction : hit

  logic setup;
  logic wr;
  logic rd_done;
  logic open_wr;
  logic running;
  logic tmo;
  logic [1:0] ev;
  logic [1:0] ev_clr;
  logic mapped;
  logic [31:0] rdata;

  always_comb begin
    s_d = s_q;
    ev = 2'h0;
    ev_clr = 2'h0;
    setup = psel & ~penable;
    wr = psel & penable & s_q.pready & pwrite;
    rd_done = psel & penable & s_q.pready & ~pwrite;
    open_wr = wr & ~s_q.locked;
    // halt pin synchroniser
    s_d.halt_s1 = cpu_halted;
    s_d.halt_s2 = s_q.halt_s1;
    // countdown
    running = s_q.irq_and_counter_enable & ~(s_q.stall_en & s_q.halt_s2); // R10
    tmo = running & (s_q.count == 32'h0000_0000); // R18
    if (running) begin
      if (tmo) begin
        s_d.raw = 1'b1; // R16
        s_d.count = s_q.reload; // R16
        ev[watchdog_timer_regs_pkg::evt_timeout_bit] = 1'b1;
        if (s_q.raw && s_q.reset_output_enable) begin
          s_d.sysrst = 1'b1; // R5 R16
          ev[watchdog_timer_regs_pkg::evt_sysreset_bit] = 1'b1;
        end
      end else begin
        s_d.count = s_q.count - 32'h0000_0001; // R18
      end
    end
    // register writes, gated by the lock except the write_lock write itself
    if (open_wr && hit(paddr, watchdog_timer_regs_pkg::interrupt_clear_off)) begin
      s_d.raw = tmo; // R6
      s_d.count = s_q.reload; // R6
    end
    if (open_wr && hit(paddr, watchdog_timer_regs_pkg::reload_interval_off)) begin
      s_d.reload = pwdata;
      s_d.count = pwdata; // R1
      if (pwdata == 32'h0000_0000) begin
        s_d.raw = 1'b1; // R2
        ev[watchdog_timer_regs_pkg::evt_timeout_bit] = 1'b1;
      end
    end
    if (open_wr && hit(paddr, watchdog_timer_regs_pkg::control_off)
        && !s_q.irq_and_counter_enable) begin // R4
      s_d.reset_output_enable = pwdata[watchdog_timer_regs_pkg::reset_output_enable_bit]; // R5
      if (pwdata[watchdog_timer_regs_pkg::irq_and_counter_enable_bit]) begin
        s_d.irq_and_counter_enable = 1'b1; // R4
        s_d.count = s_q.reload; // R17
      end
    end
    if (open_wr && hit(paddr, watchdog_timer_regs_pkg::debug_stall_control_off)) begin
      s_d.stall_en = pwdata[watchdog_timer_regs_pkg::stall_enable_bit]; // R10
    end
    if (open_wr && hit(paddr, watchdog_timer_regs_pkg::event_mask_off)) begin
      s_d.evt_mask = pwdata[1:0];
    end
    if (wr && hit(paddr, watchdog_timer_regs_pkg::write_lock_off)) begin
      s_d.locked = (pwdata != watchdog_timer_regs_pkg::lock_key_field); // R11 R12
    end
    // event status: read clears only what was reported, set wins
    if (rd_done && hit(paddr, watchdog_timer_regs_pkg::event_status_off)) begin
      ev_clr = s_q.prdata[1:0];
    end
    s_d.evt = (s_q.evt & ~ev_clr) | ev;
    // read mux, sampled in the setup cycle
    mapped = 1'b1;
    rdata = 32'h0000_0000;
    unique case (paddr)
      watchdog_timer_regs_pkg::reload_interval_off: rdata = s_q.reload;
      watchdog_timer_regs_pkg::current_count_off: rdata = s_q.count; // R3
      watchdog_timer_regs_pkg::control_off: begin
        rdata = {30'h0, s_q.reset_output_enable, s_q.irq_and_counter_enable};
      end
      watchdog_timer_regs_pkg::interrupt_clear_off: rdata = 32'h0000_0000; // R7
      watchdog_timer_regs_pkg::raw_irq_status_off: rdata = {31'h0, s_q.raw}; // R8
      watchdog_timer_regs_pkg::masked_irq_status_off: begin
        rdata = {31'h0, s_q.raw & s_q.irq_and_counter_enable}; // R9
      end
      watchdog_timer_regs_pkg::event_status_off: rdata = {30'h0, s_q.evt};
      watchdog_timer_regs_pkg::event_mask_off: rdata = {30'h0, s_q.evt_mask};
      watchdog_timer_regs_pkg::debug_stall_control_off: rdata = {23'h0, s_q.stall_en, 8'h00};
      watchdog_timer_regs_pkg::write_lock_off: begin
        rdata = s_q.locked ? watchdog_timer_regs_pkg::lock_status_locked
                           : watchdog_timer_regs_pkg::lock_status_unlocked; // R13
      end
      watchdog_timer_regs_pkg::ident_byte_4_off: rdata = {24'h0, ident_field_4}; // R14
      watchdog_timer_regs_pkg::ident_byte_5_off: rdata = {24'h0, ident_field_5}; // R14
      watchdog_timer_regs_pkg::ident_byte_6_off: rdata = {24'h0, ident_field_6}; // R14
      default: mapped = 1'b0;
    endcase
    s_d.pready = setup;
    s_d.pslverr = setup & ~mapped;
    if (setup) begin
      s_d.prdata = pwrite ? 32'h0000_0000 : rdata;
    end
    // registered outputs track next state
    s_d.timeout_irq = s_d.raw & s_d.irq_and_counter_enable; // R9
    s_d.evt_irq = |(s_d.evt & s_d.evt_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.reload <= watchdog_timer_regs_pkg::reload_interval_rst;
      s_q.count <= watchdog_timer_regs_pkg::current_count_rst;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign timeout_irq = s_q.timeout_irq;
  assign sys_reset_out = s_q.sysrst;
  assign evt_irq = s_q.evt_irq;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic wr_ok;
  assign wr_ok = psel & penable & pready & pwrite & ~s_q.locked;

  property p_load_restart;
    wr_ok && paddr == watchdog_timer_regs_pkg::reload_interval_off
      |=> s_q.count == $past(pwdata) && s_q.reload == $past(pwdata);
  endproperty
  a_load_restart: assert property (p_load_restart) else $error("load write did not restart"); // R1

  property p_load_zero;
    wr_ok && paddr == watchdog_timer_regs_pkg::reload_interval_off && pwdata == 32'h0
      |=> timeout_irq == s_q.irq_and_counter_enable && s_q.raw;
  endproperty
  a_load_zero: assert property (p_load_zero) else $error("zero load gave no interrupt"); // R2

  property p_count_read;
    psel && !penable && !pwrite && paddr == watchdog_timer_regs_pkg::current_count_off
      |=> prdata == $past(s_q.count) && pready;
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read wrong"); // R3

  property p_ctl_frozen;
    s_q.irq_and_counter_enable
      |=> s_q.irq_and_counter_enable && $stable(s_q.reset_output_enable);
  endproperty
  a_ctl_frozen: assert property (p_ctl_frozen) else $error("control changed after enable"); // R4

  property p_reset_cause;
    $rose(sys_reset_out)
      |-> $past(s_q.reset_output_enable) && $past(s_q.raw) && $past(s_q.count) == 32'h0;
  endproperty
  a_reset_cause: assert property (p_reset_cause) else $error("reset without cause"); // R5

  property p_clear;
    wr_ok && paddr == watchdog_timer_regs_pkg::interrupt_clear_off && !running
      |=> !s_q.raw && s_q.count == $past(s_q.reload);
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed"); // R6

  property p_masked;
    timeout_irq == (s_q.raw & s_q.irq_and_counter_enable);
  endproperty
  a_masked: assert property (p_masked) else $error("masked status mismatch"); // R9

  property p_stall;
    s_q.stall_en && s_q.halt_s2 && !(psel && penable)
      |=> $stable(s_q.count);
  endproperty
  a_stall: assert property (p_stall) else $error("counter moved while stalled"); // R10

  property p_lock_write;
    psel && penable && pready && pwrite && paddr == watchdog_timer_regs_pkg::write_lock_off
      |=> s_q.locked == ($past(pwdata) != watchdog_timer_regs_pkg::lock_key_field);
  endproperty
  a_lock_write: assert property (p_lock_write) else $error("lock state wrong"); // R11 R12

  property p_lock_read;
    psel && !penable && !pwrite && paddr == watchdog_timer_regs_pkg::write_lock_off
      |=> prdata == {31'h0, $past(s_q.locked)};
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock status read wrong"); // R13

  property p_ident;
    psel && !penable && !pwrite && paddr[11:4] == 8'hfd && paddr[3:0] != 4'hc
      |=> prdata[31:8] == 24'h0;
  endproperty
  a_ident: assert property (p_ident) else $error("ident upper bits set"); // R14

  property p_decrement;
    running && s_q.count != 32'h0 && !(psel && penable)
      |=> s_q.count == $past(s_q.count) - 32'h0000_0001;
  endproperty
  a_decrement: assert property (p_decrement) else $error("counter did not decrement"); // R18

  property p_enable_preload;
    wr_ok && paddr == watchdog_timer_regs_pkg::control_off && !s_q.irq_and_counter_enable
      && pwdata[watchdog_timer_regs_pkg::irq_and_counter_enable_bit]
      |=> s_q.irq_and_counter_enable && s_q.count == $past(s_q.reload);
  endproperty
  a_enable_preload: assert property (p_enable_preload) else $error("no preload"); // R17

  property p_first_timeout;
    tmo && !s_q.raw |=> s_q.raw && !$rose(sys_reset_out) && s_q.count == s_q.reload;
  endproperty
  a_first_timeout: assert property (p_first_timeout) else $error("first time-out wrong"); // R16

  property p_raw_read;
    psel && !penable && !pwrite && paddr == watchdog_timer_regs_pkg::raw_irq_status_off
      |=> prdata == {31'h0, $past(s_q.raw)};
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("raw status read wrong"); // R8

  property p_masked_read;
    psel && !penable && !pwrite && paddr == watchdog_timer_regs_pkg::masked_irq_status_off
      |=> prdata == {31'h0, $past(s_q.raw & s_q.irq_and_counter_enable)};
  endproperty
  a_masked_read: assert property (p_masked_read) else $error("masked status read wrong"); // R9

  property p_count_ro;
    wr_ok && paddr == watchdog_timer_regs_pkg::current_count_off && !running
      |=> $stable(s_q.count);
  endproperty
  a_count_ro: assert property (p_count_ro) else $error("count write took effect"); // R3

  property p_ctl_ignored;
    wr_ok && paddr == watchdog_timer_regs_pkg::control_off && s_q.irq_and_counter_enable
      |=> s_q.irq_and_counter_enable && $stable(s_q.reset_output_enable);
  endproperty
  a_ctl_ignored: assert property (p_ctl_ignored) else $error("control write not ignored"); // R4

  property p_reset_gated;
    !s_q.reset_output_enable && !sys_reset_out
      |=> !sys_reset_out;
  endproperty
  a_reset_gated: assert property (p_reset_gated) else $error("reset while disabled"); // R5

  property p_reset_sticky;
    sys_reset_out
      |=> sys_reset_out;
  endproperty
  a_reset_sticky: assert property (p_reset_sticky) else $error("system reset dropped"); // R16

  property p_clear_running;
    wr_ok && paddr == watchdog_timer_regs_pkg::interrupt_clear_off && !tmo
      |=> !s_q.raw && s_q.count == $past(s_q.reload);
  endproperty
  a_clear_running: assert property (p_clear_running) else $error("clear while running failed"); // R6

  property p_clear_set_wins;
    wr_ok && paddr == watchdog_timer_regs_pkg::interrupt_clear_off && tmo
      |=> s_q.raw;
  endproperty
  a_clear_set_wins: assert property (p_clear_set_wins) else $error("time-out lost on clear"); // R6 R16

  property p_stall_read;
    psel && !penable && !pwrite && paddr == watchdog_timer_regs_pkg::debug_stall_control_off
      |=> prdata == {23'h0, $past(s_q.stall_en), 8'h00};
  endproperty
  a_stall_read: assert property (p_stall_read) else $error("stall control read wrong"); // R10

  property p_resume;
    s_q.irq_and_counter_enable && !s_q.halt_s2 && s_q.count != 32'h0 && !(psel && penable)
      |=> s_q.count == $past(s_q.count) - 32'h0000_0001;
  endproperty
  a_resume: assert property (p_resume) else $error("counter did not run while not halted"); // R10

  property p_locked_block;
    psel && penable && pready && pwrite && s_q.locked
      && paddr != watchdog_timer_regs_pkg::write_lock_off
      |=> $stable(s_q.reload) && $stable(s_q.stall_en) && $stable(s_q.evt_mask);
  endproperty
  a_locked_block: assert property (p_locked_block) else $error("write passed the lock"); // R12

  property p_ident_4;
    psel && !penable && !pwrite && paddr == watchdog_timer_regs_pkg::ident_byte_4_off
      |=> prdata == {24'h0, ident_field_4};
  endproperty
  a_ident_4: assert property (p_ident_4) else $error("ident byte 4 wrong"); // R14

  property p_ident_5;
    psel && !penable && !pwrite && paddr == watchdog_timer_regs_pkg::ident_byte_5_off
      |=> prdata == {24'h0, ident_field_5};
  endproperty
  a_ident_5: assert property (p_ident_5) else $error("ident byte 5 wrong"); // R14

  property p_ident_6;
    psel && !penable && !pwrite && paddr == watchdog_timer_regs_pkg::ident_byte_6_off
      |=> prdata == {24'h0, ident_field_6};
  endproperty
  a_ident_6: assert property (p_ident_6) else $error("ident byte 6 wrong"); // R14

  property p_clear_read;
    psel && !penable && !pwrite && paddr == watchdog_timer_regs_pkg::interrupt_clear_off
      |=> pready && !pslverr;
  endproperty
  a_clear_read: assert property (p_clear_read) else $error("clear register read refused"); // R7

  property p_load_keeps_irq;
    wr_ok && paddr == watchdog_timer_regs_pkg::reload_interval_off && s_q.raw
      |=> s_q.raw;
  endproperty
  a_load_keeps_irq: assert property (p_load_keeps_irq) else $error("load cleared interrupt"); // R1

  property p_idle_hold;
    !s_q.irq_and_counter_enable && !(psel && penable)
      |=> $stable(s_q.count);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("counter moved while disabled"); // R18

  property p_tmo_reload;
    tmo && !(psel && penable)
      |=> s_q.count == $past(s_q.reload);
  endproperty
  a_tmo_reload: assert property (p_tmo_reload) else $error("no reload on time-out"); // R16

  property p_second_timeout;
    tmo && s_q.raw && s_q.reset_output_enable
      |=> sys_reset_out;
  endproperty
  a_second_timeout: assert property (p_second_timeout) else $error("no system reset"); // R16

  c_first_timeout: cover property (tmo && !s_q.raw);
  c_system_reset: cover property ($rose(sys_reset_out));
  c_unlock_relock: cover property (!s_q.locked ##[1:50] s_q.locked);
  c_stalled: cover property (s_q.stall_en && s_q.halt_s2 && s_q.irq_and_counter_enable);
  c_locked_write: cover property (psel && penable && pwrite && s_q.locked);

endmodule : watchdog_timer_regs

`default_nettype wire

// file: src/watchdog_timer_regs_pkg.sv
// constants, offsets and state layout of the watchdog timer block
`default_nettype none
package watchdog_timer_regs_pkg;

  localparam int addr_width = 12;
  localparam int data_width = 32;

  // register offsets, byte addresses
  localparam logic [11:0] reload_interval_off = 12'h000;
  localparam logic [11:0] current_count_off = 12'h004;
  localparam logic [11:0] control_off = 12'h008;
  localparam logic [11:0] interrupt_clear_off = 12'h00c;
  localparam logic [11:0] raw_irq_status_off = 12'h010;
  localparam logic [11:0] masked_irq_status_off = 12'h014;
  localparam logic [11:0] event_status_off = 12'h018;
  localparam logic [11:0] event_mask_off = 12'h01c;
  localparam logic [11:0] debug_stall_control_off = 12'h418;
  localparam logic [11:0] write_lock_off = 12'hc00;
  localparam logic [11:0] ident_byte_4_off = 12'hfd0;
  localparam logic [11:0] ident_byte_5_off = 12'hfd4;
  localparam logic [11:0] ident_byte_6_off = 12'hfd8;

  // field positions
  localparam int irq_and_counter_enable_bit = 0;
  localparam int reset_output_enable_bit = 1;
  localparam int stall_enable_bit = 8;
  localparam int evt_timeout_bit = 0;
  localparam int evt_sysreset_bit = 1;

  // reset values and keys
  localparam logic [31:0] reload_interval_rst = 32'hffff_ffff;
  localparam logic [31:0] current_count_rst = 32'hffff_ffff;
  localparam logic [31:0] lock_key_field = 32'h1acc_e551;
  localparam logic [31:0] lock_status_locked = 32'h0000_0001;
  localparam logic [31:0] lock_status_unlocked = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] reload;
    logic [31:0] count;
    logic irq_and_counter_enable;
    logic reset_output_enable;
    logic raw;
    logic stall_en;
    logic locked;
    logic sysrst;
    logic [1:0] evt;
    logic [1:0] evt_mask;
    logic halt_s1;
    logic halt_s2;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic timeout_irq;
    logic evt_irq;
  } wdt_state_type;

endpackage : watchdog_timer_regs_pkg
`default_nettype wire

// file: tb/tb_top.sv
// self-checking testbench for the watchdog timer register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, cpu_halted;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic pready, pslverr, timeout_irq, sys_reset_out, evt_irq;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 60074;
  typedef struct packed {logic [31:0] e; logic [31:0] m; logic err;} note_type;
  note_type q[$];
  note_type nt;
  localparam int n_cnt = 30;
  localparam logic [11:0] reset_tab [10] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h014,
    12'h418, 12'hc00, 12'hfd0, 12'hfd4, 12'hfd8};

  watchdog_timer_regs u_watchdog_timer_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_halted(cpu_halted), .timeout_irq(timeout_irq),
    .sys_reset_out(sys_reset_out), .evt_irq(evt_irq));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_reg

  function automatic logic pin_val(input int sel);
    case (sel)
      0: return timeout_irq;
      1: return sys_reset_out;
      default: return evt_irq;
    endcase
  endfunction : pin_val

  // pin compare once outputs have settled, then realign to the edge
  task automatic chk_pin(input int sel, input logic e);
    logic s;
    #1;
    s = pin_val(sel);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] pin %0d expected %b seen %b", sel, e, s);
    end
    @(posedge pclk);
  endtask : chk_pin

  task automatic wait_pin(input int sel, input int max);
    int k;
    k = 0;
    while (pin_val(sel) !== 1'b1 && k < max) begin
      @(posedge pclk);
      k++;
    end
  endtask : wait_pin

  // apb transfer; the expected answer is noted before the request goes out
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic [31:0] m, input logic err);
    int k;
    q.push_back('{e, m, err});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, e, 32'hffff_ffff, 1'b0);
  endtask : rd

  // answer watcher: oldest note against each completed transfer
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (q.size() == 0) begin
        n_errors++;
        $display("[ERR] bus answer expected none seen one");
      end else begin
        nt = q.pop_front();
        chk_reg("prdata", nt.e & nt.m, prdata & nt.m);
        chk_reg("pslverr", {31'h0, nt.err}, {31'h0, pslverr});
      end
    end
  end

  task automatic wrap_up;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cpu_halted = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 10; i++) rd(reset_tab[i], i < 2 ? 32'hffff_ffff : 32'h0);
    xfer(1'b0, 12'h020, 32'h0, 32'h0, 32'h0, 1'b1);
    xfer(1'b0, watchdog_timer_regs_pkg::interrupt_clear_off, 32'h0, 32'h0, 32'h0, 1'b0);
    wr(watchdog_timer_regs_pkg::reload_interval_off, 32'h0);
    rd(watchdog_timer_regs_pkg::raw_irq_status_off, 32'h1);
    rd(watchdog_timer_regs_pkg::masked_irq_status_off, 32'h0);
    chk_pin(0, 1'b0);
    wr(watchdog_timer_regs_pkg::event_mask_off, 32'h1);
    chk_pin(2, 1'b1);
    rd(watchdog_timer_regs_pkg::event_status_off, 32'h1);
    chk_pin(2, 1'b0);
    wr(watchdog_timer_regs_pkg::interrupt_clear_off, $random(seed));
    rd(watchdog_timer_regs_pkg::raw_irq_status_off, 32'h0);
    v = $random(seed);
    if (v == watchdog_timer_regs_pkg::lock_key_field) v = 32'h0;
    wr(watchdog_timer_regs_pkg::write_lock_off, v);
    rd(watchdog_timer_regs_pkg::write_lock_off, 32'h0000_0001);
    wr(watchdog_timer_regs_pkg::reload_interval_off, 32'h55);
    rd(watchdog_timer_regs_pkg::reload_interval_off, 32'h0);
    wr(watchdog_timer_regs_pkg::write_lock_off, watchdog_timer_regs_pkg::lock_key_field);
    rd(watchdog_timer_regs_pkg::write_lock_off, 32'h0);
    wr(watchdog_timer_regs_pkg::debug_stall_control_off, 32'h100);
    rd(watchdog_timer_regs_pkg::debug_stall_control_off, 32'h100);
    cpu_halted <= 1'b1;
    repeat (4) @(posedge pclk);
    v = $random(seed) | 32'h100;
    wr(watchdog_timer_regs_pkg::reload_interval_off, v);
    wr(watchdog_timer_regs_pkg::control_off, 32'h3);
    rd(watchdog_timer_regs_pkg::current_count_off, v);
    wr(watchdog_timer_regs_pkg::current_count_off, 32'h0);
    rd(watchdog_timer_regs_pkg::current_count_off, v);
    wr(watchdog_timer_regs_pkg::control_off, 32'h0);
    rd(watchdog_timer_regs_pkg::control_off, 32'h3);
    wr(watchdog_timer_regs_pkg::reload_interval_off, n_cnt);
    rd(watchdog_timer_regs_pkg::current_count_off, n_cnt);
    cpu_halted <= 1'b0;
    repeat (n_cnt - 6) @(posedge pclk);
    chk_pin(0, 1'b0);
    wait_pin(0, 15);
    chk_pin(0, 1'b1);
    chk_pin(1, 1'b0);
    rd(watchdog_timer_regs_pkg::masked_irq_status_off, 32'h1);
    wr(watchdog_timer_regs_pkg::interrupt_clear_off, 32'h0);
    chk_pin(0, 1'b0);
    wait_pin(0, n_cnt + 10);
    chk_pin(1, 1'b0);
    wait_pin(1, n_cnt + 10);
    chk_pin(1, 1'b1);
    rd(watchdog_timer_regs_pkg::event_status_off, 32'h0000_0003);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_pin(1, 1'b0);
    rd(watchdog_timer_regs_pkg::control_off, 32'h0);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
